// ===== i2c_target.sv
// target end: pointer-based register access over the two-wire link
// assumes SCL comes from the host and is far slower than ref_clk; no clock stretching
`timescale 1ns/1ns
module i2c_target
#(
    parameter logic [6:0] DEV_ADDR = i2c_rd_pkg::DEV_ADDR_DEFAULT
)
(
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       biasGoodIndicator,
    i2c_link_if.target      link,
    output logic            regWrite,
    output logic [7:0]      regWrIndex,
    output logic [7:0]      regWrData,
    output logic [7:0]      regIndex
);
    import i2c_rd_pkg::*;

    logic [7:0]  regs [256];

    logic        sclSync1;
    logic        sclSync2;
    logic        sclPrev;
    logic        sdaSync1;
    logic        sdaSync2;
    logic        sdaPrev;
    logic        sclRise;
    logic        sclFall;
    logic        startCond;
    logic        stopCond;

    tgtState_t   state;
    tgtState_t   next_state;
    logic [3:0]  bitCnt;
    logic [3:0]  next_bitCnt;
    logic [7:0]  shift;
    logic [7:0]  next_shift;
    logic [1:0]  kind;
    logic [1:0]  next_kind;
    logic        isRead;
    logic        next_isRead;
    logic        sdaLow;
    logic        next_sdaLow;
    logic        ackSeen;
    logic        next_ackSeen;
    logic [7:0]  next_regIndex;
    logic        next_regWrite;
    logic [7:0]  next_regWrIndex;
    logic [7:0]  next_regWrData;

    // two stages before anything looks at the pins; edge detection compares stage two with its registered copy in sclPrev/sdaPrev
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            sclSync1 <= 1'b1;
            sclSync2 <= 1'b1;
            sclPrev  <= 1'b1;
            sdaSync1 <= 1'b1;
            sdaSync2 <= 1'b1;
            sdaPrev  <= 1'b1;
        end
        else
        begin
            sclSync1 <= link.scl;
            sclSync2 <= sclSync1;
            sclPrev  <= sclSync2;
            sdaSync1 <= link.sda;
            sdaSync2 <= sdaSync1;
            sdaPrev  <= sdaSync2;
        end
    end

    assign sclRise   = sclSync2 & ~sclPrev;
    assign sclFall   = ~sclSync2 & sclPrev;
    assign startCond = sclSync2 & sclPrev & sdaPrev & ~sdaSync2;
    assign stopCond  = sclSync2 & sclPrev & ~sdaPrev & sdaSync2;

    always_comb
    begin
        next_state      = state;
        next_bitCnt     = bitCnt;
        next_shift      = shift;
        next_kind       = kind;
        next_isRead     = isRead;
        next_sdaLow     = sdaLow;
        next_ackSeen    = ackSeen;
        next_regIndex   = regIndex;
        next_regWrite   = 1'b0;
        next_regWrIndex = regWrIndex;
        next_regWrData  = regWrData;
        if (stopCond)
        begin
            // an increment already made in this byte stays in place
            next_state  = T_IDLE;
            next_sdaLow = 1'b0;
        end
        else if (startCond)
        begin
            // a start or repeated start never touches the index
            next_state  = T_RX;
            next_bitCnt = 4'h0;
            next_kind   = KIND_ADDR;
            next_sdaLow = 1'b0;
        end
        else
        begin
            unique case (state)
                T_IDLE:
                begin
                    next_sdaLow = 1'b0;
                end
                T_RX:
                begin
                    if (sclRise)
                    begin
                        next_shift  = {shift[6:0], sdaSync2};
                        next_bitCnt = bitCnt + 4'h1;
                    end
                    else if (sclFall && bitCnt == ACK_BIT)
                    begin
                        if (kind == KIND_ADDR)
                        begin
                            // other targets' traffic is ignored, so the index stands
                            if (shift[7:1] == DEV_ADDR && biasGoodIndicator)
                            begin
                                next_isRead = shift[0];
                                next_sdaLow = 1'b1;
                                next_state  = T_ACKOUT;
                            end
                            else
                            begin
                                next_state = T_IDLE;
                            end
                        end
                        else if (kind == KIND_INDEX)
                        begin
                            next_regIndex = shift;
                            next_sdaLow   = 1'b1;
                            next_state    = T_ACKOUT;
                        end
                        else
                        begin
                            next_regWrite   = 1'b1;
                            next_regWrIndex = regIndex;
                            next_regWrData  = shift;
                            next_regIndex   = regIndex + 8'h01;
                            next_sdaLow     = 1'b1;
                            next_state      = T_ACKOUT;
                        end
                    end
                end
                T_ACKOUT:
                begin
                    if (sclFall)
                    begin
                        next_bitCnt = 4'h0;
                        if (kind == KIND_ADDR && isRead == RW_READ)
                        begin
                            // first bit goes out while the host holds SCL low
                            next_shift  = regs[regIndex];
                            next_sdaLow = ~regs[regIndex][7];
                            next_state  = T_TX;
                        end
                        else
                        begin
                            next_sdaLow = 1'b0;
                            next_kind   = (kind == KIND_ADDR) ? KIND_INDEX : KIND_DATA;
                            next_state  = T_RX;
                        end
                    end
                end
                T_TX:
                begin
                    if (sclRise)
                    begin
                        if (bitCnt == INC_CLOCK)
                        begin
                            next_regIndex = regIndex + 8'h01;
                        end
                        next_bitCnt = bitCnt + 4'h1;
                    end
                    else if (sclFall)
                    begin
                        if (bitCnt == ACK_BIT)
                        begin
                            next_sdaLow = 1'b0;
                            next_state  = T_ACKIN;
                        end
                        else
                        begin
                            next_shift  = {shift[6:0], 1'b0};
                            next_sdaLow = ~shift[6];
                        end
                    end
                end
                T_ACKIN:
                begin
                    if (sclRise)
                    begin
                        next_ackSeen = ~sdaSync2;
                    end
                    else if (sclFall)
                    begin
                        if (ackSeen)
                        begin
                            // index already stepped in the previous byte
                            next_bitCnt = 4'h0;
                            next_shift  = regs[regIndex];
                            next_sdaLow = ~regs[regIndex][7];
                            next_state  = T_TX;
                        end
                        else
                        begin
                            next_state = T_IDLE;
                        end
                    end
                end
                default:
                begin
                    next_state  = T_IDLE;
                    next_sdaLow = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state      <= T_IDLE;
            bitCnt     <= 4'h0;
            shift      <= 8'h00;
            kind       <= KIND_ADDR;
            isRead     <= RW_WRITE;
            sdaLow     <= 1'b0;
            ackSeen    <= 1'b0;
            regIndex   <= INDEX_RESET;
            regWrite   <= 1'b0;
            regWrIndex <= 8'h00;
            regWrData  <= 8'h00;
        end
        else
        begin
            state      <= next_state;
            bitCnt     <= next_bitCnt;
            shift      <= next_shift;
            kind       <= next_kind;
            isRead     <= next_isRead;
            sdaLow     <= next_sdaLow;
            ackSeen    <= next_ackSeen;
            regIndex   <= next_regIndex;
            regWrite   <= next_regWrite;
            regWrIndex <= next_regWrIndex;
            regWrData  <= next_regWrData;
        end
    end

    // storage has no reset; unwritten locations read back unknown
    always_ff @(posedge ref_clk)
    begin
        if (regWrite)
        begin
            regs[regWrIndex] <= regWrData;
        end
    end

    assign link.sdaTgtOut = 1'b0;
    assign link.sdaTgtOe  = sdaLow;
endmodule

// ===== i2c_rd_pkg.sv
// shared constants and types for the register-access link (target and host ends)
// assumes both ends run on the same 100 MHz ref_clk; the host makes SCL from it
package i2c_rd_pkg;

    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          SCL_PERIOD_NS    = 1000;
    localparam int          QUARTER_CYCLES   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam logic [6:0]  DEV_ADDR_DEFAULT = 7'h08;
    localparam logic [7:0]  INDEX_RESET      = 8'h00;
    localparam logic [3:0]  INC_CLOCK        = 4'h4;
    localparam logic [3:0]  ACK_BIT          = 4'h8;
    localparam logic        RW_WRITE         = 1'b0;
    localparam logic        RW_READ          = 1'b1;
    localparam int          BUF_DEPTH        = 2;

    localparam logic [1:0]  KIND_ADDR  = 2'h0;
    localparam logic [1:0]  KIND_INDEX = 2'h1;
    localparam logic [1:0]  KIND_DATA  = 2'h2;

    localparam logic [2:0]  STEP_ADDRW = 3'h0;
    localparam logic [2:0]  STEP_INDEX = 3'h1;
    localparam logic [2:0]  STEP_WDATA = 3'h2;
    localparam logic [2:0]  STEP_ADDRR = 3'h3;
    localparam logic [2:0]  STEP_RDATA = 3'h4;

    typedef enum logic [4:0]
    {
        T_IDLE   = 5'h01,
        T_RX     = 5'h02,
        T_ACKOUT = 5'h04,
        T_TX     = 5'h08,
        T_ACKIN  = 5'h10
    } tgtState_t;

    typedef enum logic [4:0]
    {
        H_IDLE   = 5'h01,
        H_START  = 5'h02,
        H_BYTE   = 5'h04,
        H_RSTART = 5'h08,
        H_STOP   = 5'h10
    } hostState_t;

endpackage

// ===== i2c_link_if.sv
// two-wire link between host and target ends
// both wires are open drain with pull-ups; the resolved level is formed here
`timescale 1ns/1ns
interface i2c_link_if;
    logic sclHostOut;
    logic sclHostOe;
    logic sdaHostOut;
    logic sdaHostOe;
    logic sdaTgtOut;
    logic sdaTgtOe;
    logic scl;
    logic sda;

    // pull-up wins unless some end drives a low
    assign scl = ~(sclHostOe & ~sclHostOut);
    assign sda = ~((sdaHostOe & ~sdaHostOut) | (sdaTgtOe & ~sdaTgtOut));

    modport host
    (
        output sclHostOut,
        output sclHostOe,
        output sdaHostOut,
        output sdaHostOe,
        input  scl,
        input  sda
    );

    modport target
    (
        output sdaTgtOut,
        output sdaTgtOe,
        input  scl,
        input  sda
    );
endinterface

// ===== i2c_host.sv
// host end: drives SCL from ref_clk by a divider and runs write or read commands
// assumes the target never stretches SCL; read bytes leave through a small buffer
`timescale 1ns/1ns
module i2c_host
#(
    parameter logic [6:0] DEV_ADDR = i2c_rd_pkg::DEV_ADDR_DEFAULT,
    parameter int          QUARTER = i2c_rd_pkg::QUARTER_CYCLES,
    parameter int          DEPTH   = i2c_rd_pkg::BUF_DEPTH,
    parameter int          WIDTH   = 8
)
(
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    i2c_link_if.host              link,
    input  wire logic             cmdValid,
    output logic                  cmdReady,
    input  wire logic             cmdRead,
    input  wire logic             cmdSetIndex,
    input  wire logic [7:0]       cmdIndex,
    input  wire logic [7:0]       cmdData,
    input  wire logic [7:0]       cmdCount,
    output logic                  rdValid,
    input  wire logic             rdReady,
    output logic [WIDTH-1:0]      rdData,
    output logic                  done,
    output logic                  noAck
);
    import i2c_rd_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic             sdaSync1;
    logic             sdaSync2;
    hostState_t       state;
    hostState_t       next_state;
    logic [15:0]      qCnt;
    logic [15:0]      next_qCnt;
    logic [1:0]       phase;
    logic [1:0]       next_phase;
    logic [2:0]       step;
    logic [2:0]       next_step;
    logic [3:0]       bitCnt;
    logic [3:0]       next_bitCnt;
    logic [7:0]       shift;
    logic [7:0]       next_shift;
    logic [7:0]       remaining;
    logic [7:0]       next_remaining;
    logic             isRead;
    logic             next_isRead;
    logic [7:0]       index;
    logic [7:0]       next_index;
    logic [7:0]       wdata;
    logic [7:0]       next_wdata;
    logic             sclLow;
    logic             next_sclLow;
    logic             sdaLow;
    logic             next_sdaLow;
    logic             ackBit;
    logic             next_ackBit;
    logic             next_done;
    logic             next_noAck;
    logic             tick;
    logic             stall;
    logic             push;
    logic             pop;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr;
    logic [PW-1:0]    rdPtr;
    logic [CW-1:0]    count;

    function automatic logic [7:0] byteFor(input logic [2:0] s, input logic [7:0] ix, input logic [7:0] wd);
        logic [7:0] b;
        b = 8'h00;
        if (s == STEP_ADDRW) b = {DEV_ADDR, RW_WRITE};
        if (s == STEP_INDEX) b = ix;
        if (s == STEP_WDATA) b = wd;
        if (s == STEP_ADDRR) b = {DEV_ADDR, RW_READ};
        return b;
    endfunction

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            sdaSync1 <= 1'b1;
            sdaSync2 <= 1'b1;
        end
        else
        begin
            sdaSync1 <= link.sda;
            sdaSync2 <= sdaSync1;
        end
    end

    assign tick     = (qCnt == 16'(QUARTER - 1));
    // SCL is held low before a read byte while the buffer is full
    assign stall    = (state == H_BYTE) && (step == STEP_RDATA) && (bitCnt == 4'h0) && (phase == 2'h0)
                      && (count == CW'(DEPTH));
    assign cmdReady = (state == H_IDLE);

    always_comb
    begin
        next_state = state; next_qCnt = qCnt; next_phase = phase; next_step = step;
        next_bitCnt = bitCnt; next_shift = shift; next_remaining = remaining;
        next_isRead = isRead; next_index = index; next_wdata = wdata;
        next_sclLow = sclLow; next_sdaLow = sdaLow; next_ackBit = ackBit;
        next_done = 1'b0; next_noAck = 1'b0; push = 1'b0;
        if (state == H_IDLE)
        begin
            next_qCnt  = 16'h0000;
            next_phase = 2'h0;
            if (cmdValid)
            begin
                next_isRead    = cmdRead;
                next_index     = cmdIndex;
                next_wdata     = cmdData;
                next_remaining = cmdCount;
                // index write first unless a read wants the retained pointer
                next_step      = (cmdRead && !cmdSetIndex) ? STEP_ADDRR : STEP_ADDRW;
                next_state     = H_START;
            end
        end
        else if (stall)
        begin
            next_qCnt = 16'h0000;
        end
        else if (!tick)
        begin
            next_qCnt = qCnt + 16'h0001;
        end
        else
        begin
            next_qCnt  = 16'h0000;
            next_phase = phase + 2'h1;
            unique case (state)
                H_START, H_RSTART:
                begin
                    if (phase == 2'h0) next_sdaLow = 1'b0;
                    if (phase == 2'h1) next_sclLow = 1'b0;
                    if (phase == 2'h2) next_sdaLow = 1'b1;
                    if (phase == 2'h3)
                    begin
                        next_sclLow = 1'b1;
                        next_bitCnt = 4'h0;
                        next_shift  = byteFor(step, index, wdata);
                        next_state  = H_BYTE;
                    end
                end
                H_BYTE:
                begin
                    if (phase == 2'h0)
                    begin
                        if (bitCnt != ACK_BIT)
                            next_sdaLow = (step != STEP_RDATA) ? ~shift[7] : 1'b0;
                        else
                            next_sdaLow = (step == STEP_RDATA) && (remaining != 8'h01);
                    end
                    if (phase == 2'h1) next_sclLow = 1'b0;
                    if (phase == 2'h2)
                    begin
                        if (bitCnt != ACK_BIT) next_shift = {shift[6:0], sdaSync2};
                        else next_ackBit = ~sdaSync2;
                    end
                    if (phase == 2'h3)
                    begin
                        next_sclLow = 1'b1;
                        next_bitCnt = bitCnt + 4'h1;
                        if (bitCnt == ACK_BIT)
                        begin
                            next_bitCnt = 4'h0;
                            if (step == STEP_RDATA)
                            begin
                                push           = 1'b1;
                                next_remaining = remaining - 8'h01;
                                if (remaining == 8'h01) next_state = H_STOP;
                            end
                            else if (!ackBit)
                            begin
                                next_noAck = 1'b1;
                                next_state = H_STOP;
                            end
                            else if (step == STEP_ADDRW) begin next_step = STEP_INDEX; next_shift = index; end
                            else if (step == STEP_INDEX && isRead) begin next_step = STEP_ADDRR; next_state = H_RSTART; end
                            else if (step == STEP_INDEX) begin next_step = STEP_WDATA; next_shift = wdata; end
                            else if (step == STEP_ADDRR) next_step = STEP_RDATA;
                            else next_state = H_STOP;
                        end
                    end
                end
                H_STOP:
                begin
                    if (phase == 2'h0) next_sdaLow = 1'b1;
                    if (phase == 2'h1) next_sclLow = 1'b0;
                    if (phase == 2'h2) next_sdaLow = 1'b0;
                    if (phase == 2'h3)
                    begin
                        next_done  = 1'b1;
                        next_state = H_IDLE;
                    end
                end
                default: next_state = H_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state <= H_IDLE; qCnt <= 16'h0000; phase <= 2'h0; step <= STEP_ADDRW;
            bitCnt <= 4'h0; shift <= 8'h00; remaining <= 8'h00; isRead <= 1'b0;
            index <= 8'h00; wdata <= 8'h00; sclLow <= 1'b0; sdaLow <= 1'b0;
            ackBit <= 1'b0; done <= 1'b0; noAck <= 1'b0;
        end
        else
        begin
            state <= next_state; qCnt <= next_qCnt; phase <= next_phase; step <= next_step;
            bitCnt <= next_bitCnt; shift <= next_shift; remaining <= next_remaining; isRead <= next_isRead;
            index <= next_index; wdata <= next_wdata; sclLow <= next_sclLow; sdaLow <= next_sdaLow;
            ackBit <= next_ackBit; done <= next_done; noAck <= next_noAck;
        end
    end

    // read-data buffer; push cannot meet a full buffer because of the stall
    assign pop     = rdValid && rdReady;
    assign rdValid = (count != '0);
    assign rdData  = mem[rdPtr];

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                mem[wrPtr] <= WIDTH'(shift);
                wrPtr      <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + PW'(1);
            end
            if (pop)
                rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + PW'(1);
            count <= count + CW'(push) - CW'(pop);
        end
    end

    assign link.sclHostOut = 1'b0;
    assign link.sclHostOe  = sclLow;
    assign link.sdaHostOut = 1'b0;
    assign link.sdaHostOe  = sdaLow;
endmodule

// ===== i2c_target_register_read_checker.sv
// wire-level checks on the two-wire link between host and target ends
// assumes QUARTER of at least 8 ref_clk cycles; instantiated beside the link interface
`timescale 1ns/1ns
module i2c_target_register_read_checker
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic sclHostOut,
    input wire logic sclHostOe,
    input wire logic sdaHostOut,
    input wire logic sdaHostOe,
    input wire logic sdaTgtOut,
    input wire logic sdaTgtOe,
    input wire logic scl,
    input wire logic sda,
    input wire logic biasGood
);
    logic [3:0] lowCnt;
    logic [3:0] next_lowCnt;

    // cycles since scl went low, saturating so long stalls do not wrap
    always_comb next_lowCnt = scl ? 4'h0 : ((lowCnt == 4'hf) ? lowCnt : lowCnt + 4'h1);
    always_ff @(posedge ref_clk) lowCnt <= sys_rst ? 4'h0 : next_lowCnt;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence sclLowHold;
        sclHostOe [*8];
    endsequence
    sequence sclHighHold;
        !sclHostOe [*8];
    endsequence

    tgt_bias_gate_a: assert property (!biasGood |-> !sdaTgtOe && !sdaTgtOut)
        else $error("target drove data while bias not good");
    host_open_drain_a: assert property (!sclHostOut && !sdaHostOut) else $error("host output not low");
    reset_release_a: assert property (disable iff (1'b0) sys_rst |=> !sdaTgtOe && !sdaHostOe && !sclHostOe)
        else $error("link driven right after reset");
    scl_low_hold_a: assert property ($rose(sclHostOe) |-> sclLowHold) else $error("scl low too short");
    scl_high_hold_a: assert property ($fell(sclHostOe) |-> sclHighHold) else $error("scl high too short");
    tgt_change_window_a: assert property ($changed(sdaTgtOe) |-> !scl && lowCnt >= 4'h1 && lowCnt <= 4'h8)
        else $error("target data changed outside scl low window");
    no_tgt_frame_a: assert property (scl && $past(scl) && $changed(sda) |-> !sdaTgtOe)
        else $error("start or stop while target drives");
    tgt_hold_high_a: assert property ($rose(scl) && sdaTgtOe |=> sdaTgtOe [*8])
        else $error("target released data while scl high");
endmodule

// ===== test_i2c_target_register_read.sv
// self-checking bench: host end talks to target end across the link interface
// assumes pull-ups resolved in the interface; QUARTER shortened to 8 cycles
`timescale 1ns/1ns
module test_i2c_target_register_read;
    import i2c_rd_pkg::*;
    logic       ref_clk = 1'b0, sys_rst = 1'b1, biasGood = 1'b1, cmdValid = 1'b0, cmdRead = 1'b0;
    logic       cmdSetIndex = 1'b0, rdReady = 1'b1, sawNack = 1'b0;
    logic [7:0] cmdIndex = 8'h00, cmdData = 8'h00, cmdCount = 8'h01, lastIx, lastDt;
    logic       cmdReady, rdValid, done, noAck, regWrite;
    logic [7:0] rdData, regWrIndex, regWrData, regIndex;
    logic [7:0] got [$];
    logic [7:0] ixTab [5] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'hff};
    logic [7:0] dtTab [5] = '{8'ha5, 8'h3c, 8'h5a, 8'hc3, 8'h96};
    int         failures = 0, checks_done = 0, cycles = 0;

    i2c_link_if i2c_link_if_i ();
    i2c_host #(.QUARTER(8)) i2c_host_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(i2c_link_if_i.host),
        .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdRead(cmdRead), .cmdSetIndex(cmdSetIndex),
        .cmdIndex(cmdIndex), .cmdData(cmdData), .cmdCount(cmdCount), .rdValid(rdValid), .rdReady(rdReady),
        .rdData(rdData), .done(done), .noAck(noAck));
    i2c_target i2c_target_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .biasGoodIndicator(biasGood),
        .link(i2c_link_if_i.target), .regWrite(regWrite), .regWrIndex(regWrIndex), .regWrData(regWrData),
        .regIndex(regIndex));
    i2c_target_register_read_checker i2c_target_register_read_checker_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .sclHostOut(i2c_link_if_i.sclHostOut), .sclHostOe(i2c_link_if_i.sclHostOe),
        .sdaHostOut(i2c_link_if_i.sdaHostOut), .sdaHostOe(i2c_link_if_i.sdaHostOe),
        .sdaTgtOut(i2c_link_if_i.sdaTgtOut), .sdaTgtOe(i2c_link_if_i.sdaTgtOe),
        .scl(i2c_link_if_i.scl), .sda(i2c_link_if_i.sda), .biasGood(biasGood));

    initial forever #5 ref_clk = ~ref_clk;

    // one-cycle pulses are caught mid-cycle while they stand
    always @(negedge ref_clk)
    begin
        if (regWrite === 1'b1) {lastIx, lastDt} = {regWrIndex, regWrData};
        if (noAck === 1'b1) sawNack = 1'b1;
    end

    // pops are taken at the edge that performs them; rdReady moves on the falling edge, so no race
    always @(posedge ref_clk)
    begin
        if (rdValid === 1'b1 && rdReady === 1'b1) got.push_back(rdData);
        cycles++;
        if (cycles == 60000)
        begin
            failures++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] a, input logic [7:0] e);
        checks_done++;
        if (a !== e)
        begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask

    task automatic run_cmd(input logic rd, input logic si, input logic [7:0] ix, dt, cn);
        @(negedge ref_clk);
        {cmdRead, cmdSetIndex, cmdIndex, cmdData, cmdCount} = {rd, si, ix, dt, cn};
        {cmdValid, sawNack} = 2'b10;
        got.delete();
        do @(posedge ref_clk); while (cmdReady !== 1'b1);
        @(negedge ref_clk);
        cmdValid = 1'b0;
        while (done !== 1'b1) @(negedge ref_clk);
    endtask

    task automatic rd_test(input logic si, input logic [7:0] ix, cn, input int k, input logic [7:0] endIx);
        run_cmd(1'b1, si, ix, 8'h00, cn);
        check(8'(got.size()), cn);
        for (int i = 0; i < cn; i++) check(got[i], dtTab[k + i]);
        check(regIndex, endIx);
    endtask

    task automatic t_writes();
        for (int k = 0; k < 5; k++)
        begin
            run_cmd(1'b0, 1'b1, ixTab[k], dtTab[k], 8'h01);
            check(lastIx, ixTab[k]);
            check(lastDt, dtTab[k]);
            check(regIndex, ixTab[k] + 8'h01);
        end
    endtask

    task automatic t_multi_stall();
        rdReady = 1'b0;
        // long enough for the two-entry buffer to fill so the host must hold scl
        fork
            begin
                repeat (3000) @(negedge ref_clk);
                check({7'h0, cmdReady}, 8'h00);
                rdReady = 1'b1;
            end
        join_none
        rd_test(1'b1, 8'h10, 8'h03, 0, 8'h13);
    endtask

    task automatic t_bias_low();
        biasGood = 1'b0;
        run_cmd(1'b1, 1'b1, 8'h10, 8'h00, 8'h01);
        check({7'h0, sawNack}, 8'h01);
        check(8'(got.size()), 8'h00);
        check(regIndex, 8'h00);
        biasGood = 1'b1;
    endtask

    initial
    begin
        repeat (4) @(negedge ref_clk);
        sys_rst = 1'b0;
        t_writes();
        t_multi_stall();
        rd_test(1'b0, 8'h00, 8'h01, 3, 8'h14);
        repeat (2) rd_test(1'b1, 8'h11, 8'h01, 1, 8'h12);
        rd_test(1'b1, 8'hff, 8'h01, 4, 8'h00);
        t_bias_low();
        summarize();
    end
endmodule
